// ===== logic/esr_event_reg.sv
`timescale 1ns/1ps
module esr_event_reg #(
   parameter int W = 8,
   parameter logic [W-1:0] USED = '1,
   parameter logic [W-1:0] RESET = '0
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Flag and mask access
   esr_evt_if.owner evt
);

   logic [W-1:0] flags_ff;
   logic [W-1:0] nxt_flags;
   logic [W-1:0] mask_ff;
   logic [W-1:0] nxt_mask;

   // Clear and set in one cycle: the new event survives
   always_comb begin
      nxt_flags = (evt.clr ? '0 : flags_ff) | (evt.set & USED);
      nxt_mask = evt.mask_wr ? evt.mask_din : mask_ff;
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         flags_ff <= RESET & USED;
         mask_ff <= '0;
      end else begin
         flags_ff <= nxt_flags;
         mask_ff <= nxt_mask;
      end
   end

   assign evt.flags = flags_ff;
   assign evt.mask = mask_ff;
   assign evt.summary = |(flags_ff & mask_ff & USED);

   property p_set_wins;
      @(posedge i_sys_clk) disable iff (i_reset)
      (|(evt.set & USED)) |=> ((evt.flags & $past(evt.set & USED)) == $past(evt.set & USED));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   property p_unused_zero;
      @(posedge i_sys_clk) disable iff (i_reset)
      (evt.flags & ~USED) == '0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused flag bit set");

endmodule // esr_event_reg

// ===== logic/esr_evt_if.sv
`timescale 1ns/1ps
interface esr_evt_if #(parameter int W = 8);
   logic [W-1:0] set;
   logic clr;
   logic mask_wr;
   logic [W-1:0] mask_din;
   logic [W-1:0] flags;
   logic [W-1:0] mask;
   logic summary;

   modport owner (
      input set, clr, mask_wr, mask_din,
      output flags, mask, summary
   );
   modport user (
      output set, clr, mask_wr, mask_din,
      input flags, mask, summary
   );
endinterface

// ===== logic/esr_pkg.sv
package esr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int REG_W = 8;
   localparam int CMP_W = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Status byte bit positions
   localparam int STB_MEAS_SUM = 0;
   localparam int STB_CMP_SUM = 1;
   localparam int STB_MAV = 4;
   localparam int STB_STD_SUM = 5;
   localparam int STB_MSS = 6;
   // Bits that take part in the request summary
   localparam logic [7:0] STB_USED = 8'h33;

   ////////////////////////////////////////////////////////////////////////////
   // Standard event flag positions
   localparam int STD_OPC = 0;
   localparam int STD_QRY = 2;
   localparam int STD_INTERNAL = 3;
   localparam int STD_EXEC = 4;
   localparam int STD_CMD = 5;
   localparam int STD_POWER = 7;
   localparam logic [7:0] STD_USED = 8'hBD;
   localparam logic [7:0] STD_RESET = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // Measurement event flag positions
   localparam int MEAS_CONV = 0;
   localparam int MEAS_END = 1;
   localparam int MEAS_FAULT = 5;
   localparam logic [7:0] MEAS_USED = 8'h23;

   ////////////////////////////////////////////////////////////////////////////
   // Comparator flags: resistance low/in/high in 0..2, voltage low/in/high in 3..5
   localparam int CMP_LSB = 0;
   localparam logic [7:0] CMP_USED = 8'h3F;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values of masks and the response register
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded remote commands
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_CLS = 4'h1,
      CMD_SRE_WR = 4'h2,
      CMD_SRE_RD = 4'h3,
      CMD_STD_RD = 4'h4,
      CMD_STDM_WR = 4'h5,
      CMD_STDM_RD = 4'h6,
      CMD_MEAS_RD = 4'h7,
      CMD_MEASM_WR = 4'h8,
      CMD_MEASM_RD = 4'h9,
      CMD_CMP_RD = 4'hA,
      CMD_CMPM_WR = 4'hB,
      CMD_CMPM_RD = 4'hC,
      CMD_STB_RD = 4'hD,
      CMD_POLL = 4'hE,
      CMD_OPC = 4'hF
   } esr_cmd_t;

   typedef enum logic [1:0] {
      OPC_IDLE = 2'b00,
      OPC_WAIT = 2'b01
   } esr_opc_st_t;

endpackage

// ===== logic/esr_srq.sv
`timescale 1ns/1ps
module esr_srq (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Status byte and mask
   input wire logic [7:0] i_stb_bits,
   input wire logic [7:0] i_sre,
   // Clear strobes
   input wire logic i_poll,
   input wire logic i_cls,
   // Summary outputs
   output logic o_mss,
   output logic o_srq
);

   logic [7:0] enabled;
   logic [7:0] prev_ff;
   logic [7:0] nxt_prev;
   logic srq_ff;
   logic nxt_srq;
   logic rise;

   assign enabled = i_stb_bits & i_sre & esr_pkg::STB_USED;
   assign rise = |(enabled & ~prev_ff);

   // poll clears request; a fresh rise in the same cycle wins
   always_comb begin
      nxt_prev = enabled;
      nxt_srq = rise | (srq_ff & ~(i_poll | i_cls));
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         prev_ff <= esr_pkg::ZERO_BYTE;
         srq_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
         srq_ff <= nxt_srq;
      end
   end

   // Summary is the live OR so it drops once the sources are cleared
   assign o_mss = |enabled;
   assign o_srq = srq_ff;

   property p_rise_req;
      @(posedge i_sys_clk) disable iff (i_reset)
      rise |=> o_srq;
   endproperty
   a_rise_req: assert property (p_rise_req) else $error("request not raised");

   property p_poll_clear;
      @(posedge i_sys_clk) disable iff (i_reset)
      (i_poll && !rise) |=> !o_srq;
   endproperty
   a_poll_clear: assert property (p_poll_clear) else $error("poll did not clear");

endmodule // esr_srq

// ===== logic/esr_top.sv
// Operation
// - A service mask bit at one lets its status byte bit into the summary.
// - Enabled standard event flags set status byte bit 5.
// - Standard flags clear at power-up, clear-status, and on their query.
// - Power-up flag, bit 7, sets at power-up and on outage recovery.
// - Command fault sets bit 5 and discards the rest of the message.
// - Execution fault sets bit 4 when a valid command cannot run.
// - Internal fault sets bit 3 on other command failures.
// - Query fault sets bit 2 and clears the output queue.
// - On GP-IB, operation complete sets bit 0 after prior messages finish.
// - Standard event mask bit at one lets its flag into bit 5.
// - Enabled measure flags set status bit 0; comparator flags set bit 1.
// - Both device flag registers clear at power-up, clear-status, own query.
// - Measure flags: fault bit 5, measurement end bit 1, conversion end bit 0.
// - Comparator flags: voltage high/in/low bits 5-3, resistance bits 2-0.
// - Enabled status bit rising sets summary bit 6 and raises a request.
// - Serial poll clears the request; summary clears once its enabled status bits clear.
// - Status bit 4 shows a message waiting in the output queue.
`timescale 1ns/1ps
module esr_top (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Decoded command and response
   input wire logic i_cmd_valid,
   input wire esr_pkg::esr_cmd_t i_cmd_code,
   input wire logic [7:0] i_cmd_data,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_data,
   // Interface mode and progress
   input wire logic i_gpib_mode,
   input wire logic i_ops_idle,
   input wire logic i_power_restore,
   // Command error sources
   input wire logic i_cmd_fault,
   input wire logic i_exec_fault,
   input wire logic i_internal_fault,
   // Output queue state and errors
   input wire logic i_msg_avail,
   input wire logic i_queue_overflow,
   input wire logic i_queue_lost,
   input wire logic i_queue_empty_read,
   // Measurement events
   input wire logic i_meas_fault,
   input wire logic i_meas_end,
   input wire logic i_conv_done,
   input wire logic [5:0] i_cmp_result,
   input wire logic i_cmp_valid,
   // Side effects and request
   output logic o_queue_clear,
   output logic o_discard_msg,
   output logic o_srq
);

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   logic cmd_cls;
   logic cmd_poll;
   logic query_fault;
   logic [7:0] sre_ff;
   logic [7:0] nxt_sre;
   logic [7:0] stb_bits;
   logic mss;

   esr_evt_if #(.W(esr_pkg::REG_W)) std_if ();
   esr_evt_if #(.W(esr_pkg::REG_W)) meas_if ();
   esr_evt_if #(.W(esr_pkg::REG_W)) cmp_if ();

   assign cmd_cls = i_cmd_valid && (i_cmd_code == esr_pkg::CMD_CLS);
   assign cmd_poll = i_cmd_valid && (i_cmd_code == esr_pkg::CMD_POLL);

   // query fault sources; empty read counts on GP-IB only
   assign query_fault = i_queue_overflow | i_queue_lost | (i_queue_empty_read & i_gpib_mode);

   ////////////////////////////////////////////////////////////////////////////
   // Operation complete tracking

   esr_pkg::esr_opc_st_t opc_st_ff;
   esr_pkg::esr_opc_st_t nxt_opc_st;
   logic opc_set;

   always_comb begin
      nxt_opc_st = opc_st_ff;
      opc_set = 1'b0;
      case (opc_st_ff)
         esr_pkg::OPC_IDLE: begin
            if (i_cmd_valid && (i_cmd_code == esr_pkg::CMD_OPC) && i_gpib_mode) begin
               nxt_opc_st = esr_pkg::OPC_WAIT;
            end
         end
         esr_pkg::OPC_WAIT: begin
            if (i_ops_idle) begin
               opc_set = 1'b1;
               nxt_opc_st = esr_pkg::OPC_IDLE;
            end
         end
         default: begin
            nxt_opc_st = esr_pkg::OPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         opc_st_ff <= esr_pkg::OPC_IDLE;
      end else begin
         opc_st_ff <= nxt_opc_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event registers

   always_comb begin
      std_if.set = esr_pkg::ZERO_BYTE;
      std_if.set[esr_pkg::STD_POWER] = i_power_restore;
      std_if.set[esr_pkg::STD_CMD] = i_cmd_fault;
      std_if.set[esr_pkg::STD_EXEC] = i_exec_fault;
      std_if.set[esr_pkg::STD_INTERNAL] = i_internal_fault;
      std_if.set[esr_pkg::STD_QRY] = query_fault;
      std_if.set[esr_pkg::STD_OPC] = opc_set;
      std_if.clr = cmd_cls || (i_cmd_valid && (i_cmd_code == esr_pkg::CMD_STD_RD));
      std_if.mask_wr = i_cmd_valid && (i_cmd_code == esr_pkg::CMD_STDM_WR);
      std_if.mask_din = i_cmd_data;

      meas_if.set = esr_pkg::ZERO_BYTE;
      meas_if.set[esr_pkg::MEAS_FAULT] = i_meas_fault;
      meas_if.set[esr_pkg::MEAS_END] = i_meas_end;
      meas_if.set[esr_pkg::MEAS_CONV] = i_conv_done;
      // clear on clear-status or own query
      meas_if.clr = cmd_cls || (i_cmd_valid && (i_cmd_code == esr_pkg::CMD_MEAS_RD));
      meas_if.mask_wr = i_cmd_valid && (i_cmd_code == esr_pkg::CMD_MEASM_WR);
      meas_if.mask_din = i_cmd_data;

      cmp_if.set = esr_pkg::ZERO_BYTE;
      if (i_cmp_valid) begin
         cmp_if.set[esr_pkg::CMP_LSB +: esr_pkg::CMP_W] = i_cmp_result;
      end
      cmp_if.clr = cmd_cls || (i_cmd_valid && (i_cmd_code == esr_pkg::CMD_CMP_RD));
      cmp_if.mask_wr = i_cmd_valid && (i_cmd_code == esr_pkg::CMD_CMPM_WR);
      cmp_if.mask_din = i_cmd_data;
   end

   // standard flags, 8 bits, power-up flag preset
   esr_event_reg #(
      .W(esr_pkg::REG_W),
      .USED(esr_pkg::STD_USED),
      .RESET(esr_pkg::STD_RESET)
   ) u_std (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .evt(std_if.owner)
   );

   // measure flags feed status bit 0
   esr_event_reg #(
      .W(esr_pkg::REG_W),
      .USED(esr_pkg::MEAS_USED),
      .RESET(esr_pkg::ZERO_BYTE)
   ) u_meas (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .evt(meas_if.owner)
   );

   // comparator flags feed status bit 1; upper two bits left unused
   esr_event_reg #(
      .W(esr_pkg::REG_W),
      .USED(esr_pkg::CMP_USED),
      .RESET(esr_pkg::ZERO_BYTE)
   ) u_cmp (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .evt(cmp_if.owner)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status byte and service request

   always_comb begin
      stb_bits = esr_pkg::ZERO_BYTE;
      stb_bits[esr_pkg::STB_MEAS_SUM] = meas_if.summary;
      stb_bits[esr_pkg::STB_CMP_SUM] = cmp_if.summary;
      stb_bits[esr_pkg::STB_MAV] = i_msg_avail;
      stb_bits[esr_pkg::STB_STD_SUM] = std_if.summary;
   end

   esr_srq u_srq (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_stb_bits(stb_bits),
      .i_sre(sre_ff),
      .i_poll(cmd_poll),
      .i_cls(cmd_cls),
      .o_mss(mss),
      .o_srq(o_srq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Service mask, responses and side-effect pulses

   logic rsp_valid_ff;
   logic nxt_rsp_valid;
   logic [7:0] rsp_data_ff;
   logic [7:0] nxt_rsp_data;
   logic queue_clear_ff;
   logic nxt_queue_clear;
   logic discard_ff;
   logic nxt_discard;

   always_comb begin
      nxt_sre = sre_ff;
      nxt_rsp_valid = 1'b0;
      nxt_rsp_data = rsp_data_ff;
      nxt_queue_clear = query_fault;
      nxt_discard = i_cmd_fault;
      if (i_cmd_valid) begin
         nxt_rsp_valid = 1'b1;
         case (i_cmd_code)
            esr_pkg::CMD_SRE_WR: begin
               nxt_sre = i_cmd_data;
               nxt_rsp_valid = 1'b0;
            end
            esr_pkg::CMD_SRE_RD: nxt_rsp_data = sre_ff;
            esr_pkg::CMD_STD_RD: nxt_rsp_data = std_if.flags;
            esr_pkg::CMD_STDM_RD: nxt_rsp_data = std_if.mask;
            esr_pkg::CMD_MEAS_RD: nxt_rsp_data = meas_if.flags;
            esr_pkg::CMD_MEASM_RD: nxt_rsp_data = meas_if.mask;
            esr_pkg::CMD_CMP_RD: nxt_rsp_data = cmp_if.flags;
            esr_pkg::CMD_CMPM_RD: nxt_rsp_data = cmp_if.mask;
            esr_pkg::CMD_STB_RD: begin
               // query shows summary without clearing it
               nxt_rsp_data = stb_bits;
               nxt_rsp_data[esr_pkg::STB_MSS] = mss;
            end
            esr_pkg::CMD_POLL: begin
               nxt_rsp_data = stb_bits;
               nxt_rsp_data[esr_pkg::STB_MSS] = o_srq;
            end
            default: begin
               nxt_rsp_valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         sre_ff <= esr_pkg::MASK_RESET;
         rsp_valid_ff <= 1'b0;
         rsp_data_ff <= esr_pkg::ZERO_BYTE;
         queue_clear_ff <= 1'b0;
         discard_ff <= 1'b0;
      end else begin
         sre_ff <= nxt_sre;
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_data_ff <= nxt_rsp_data;
         queue_clear_ff <= nxt_queue_clear;
         discard_ff <= nxt_discard;
      end
   end

   assign o_rsp_valid = rsp_valid_ff;
   assign o_rsp_data = rsp_data_ff;
   assign o_queue_clear = queue_clear_ff;
   assign o_discard_msg = discard_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_mask_block;
      (sre_ff == esr_pkg::ZERO_BYTE) |-> !mss;
   endproperty
   a_mask_block: assert property (p_mask_block) else $error("masked bit reached summary");

   property p_std_sum;
      (|(std_if.flags & std_if.mask)) |-> stb_bits[esr_pkg::STB_STD_SUM];
   endproperty
   a_std_sum: assert property (p_std_sum) else $error("standard summary missing");

   property p_std_read_clear;
      (i_cmd_valid && i_cmd_code == esr_pkg::CMD_STD_RD && std_if.set == esr_pkg::ZERO_BYTE)
      |=> (std_if.flags == esr_pkg::ZERO_BYTE) && (o_rsp_data == $past(std_if.flags));
   endproperty
   a_std_read_clear: assert property (p_std_read_clear) else $error("query did not clear");

   property p_power_set;
      i_power_restore |=> std_if.flags[esr_pkg::STD_POWER];
   endproperty
   a_power_set: assert property (p_power_set) else $error("power flag missing");

   property p_cmd_fault;
      i_cmd_fault |=> std_if.flags[esr_pkg::STD_CMD] && o_discard_msg;
   endproperty
   a_cmd_fault: assert property (p_cmd_fault) else $error("command fault not handled");

   property p_query_fault;
      i_queue_overflow |=> o_queue_clear && std_if.flags[esr_pkg::STD_QRY];
   endproperty
   a_query_fault: assert property (p_query_fault) else $error("queue not flushed");

   property p_opc_done;
      (opc_st_ff == esr_pkg::OPC_WAIT && i_ops_idle) |=> std_if.flags[esr_pkg::STD_OPC];
   endproperty
   a_opc_done: assert property (p_opc_done) else $error("complete flag missing");

   property p_opc_serial;
      (!i_gpib_mode && opc_st_ff == esr_pkg::OPC_IDLE) |=> opc_st_ff == esr_pkg::OPC_IDLE;
   endproperty
   a_opc_serial: assert property (p_opc_serial) else $error("complete armed off GP-IB");

   property p_meas_sum;
      (|(meas_if.flags & meas_if.mask)) |-> stb_bits[esr_pkg::STB_MEAS_SUM];
   endproperty
   a_meas_sum: assert property (p_meas_sum) else $error("measure summary missing");

   property p_mav;
      stb_bits[esr_pkg::STB_MAV] == i_msg_avail;
   endproperty
   a_mav: assert property (p_mav) else $error("message bit wrong");

   property p_stb_query_keeps;
      (i_cmd_valid && i_cmd_code == esr_pkg::CMD_STB_RD && o_srq) |=> o_srq;
   endproperty
   a_stb_query_keeps: assert property (p_stb_query_keeps) else $error("query cleared request");

endmodule // esr_top

// ===== verif/esr_host_model.sv
`timescale 1ns/1ps
module esr_host_model (
   // Clock
   input wire logic i_sys_clk,
   // Command port toward the device
   output logic o_cmd_valid,
   output esr_pkg::esr_cmd_t o_cmd_code,
   output logic [7:0] o_cmd_data
);
   logic [11:0] pend[$];
   logic [11:0] w;

   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_code = esr_pkg::CMD_NOP;
      o_cmd_data = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One command a cycle at most, so back-to-back requests stay possible
   always @(posedge i_sys_clk) begin
      #1;
      if (pend.size() > 0) begin
         w = pend.pop_front();
         o_cmd_valid = 1'b1;
         o_cmd_code = esr_pkg::esr_cmd_t'(w[11:8]);
         o_cmd_data = w[7:0];
      end else begin
         // Idle lines show garbage, not the last command
         o_cmd_valid = 1'b0;
         o_cmd_code = esr_pkg::esr_cmd_t'(~o_cmd_code);
         o_cmd_data = ~o_cmd_data;
      end
   end

   task automatic send(input esr_pkg::esr_cmd_t code, input logic [7:0] data);
      pend.push_back({code, data});
   endtask
endmodule // esr_host_model

// ===== verif/test_esr_top.sv
`timescale 1ns/1ps
module test_esr_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid;
   esr_pkg::esr_cmd_t cmd_code;
   logic [7:0] cmd_data;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic gpib = 1'b1;
   logic idle = 1'b0;
   logic avail = 1'b0;
   logic [10:0] ev = '0;
   logic [5:0] cmp = '0;
   logic qclr, disc, srq, seen_qc, seen_dm;
   logic [7:0] r;
   logic [7:0] expq[$];
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int ev_bit[7] = '{5, 4, 3, 2, 2, 2, 7};
   esr_pkg::esr_cmd_t wr_c[4] = '{esr_pkg::CMD_SRE_WR, esr_pkg::CMD_STDM_WR,
                                  esr_pkg::CMD_MEASM_WR, esr_pkg::CMD_CMPM_WR};
   esr_pkg::esr_cmd_t rd_c[4] = '{esr_pkg::CMD_SRE_RD, esr_pkg::CMD_STDM_RD,
                                  esr_pkg::CMD_MEASM_RD, esr_pkg::CMD_CMPM_RD};

   always #50 clk = ~clk;

   esr_host_model esr_host_model_i (.i_sys_clk(clk), .o_cmd_valid(cmd_valid),
      .o_cmd_code(cmd_code), .o_cmd_data(cmd_data));

   esr_top esr_top_i (.i_sys_clk(clk), .i_reset(rst), .i_cmd_valid(cmd_valid),
      .i_cmd_code(cmd_code), .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid),
      .o_rsp_data(rsp_data), .i_gpib_mode(gpib), .i_ops_idle(idle),
      .i_power_restore(ev[6]), .i_cmd_fault(ev[0]), .i_exec_fault(ev[1]),
      .i_internal_fault(ev[2]), .i_msg_avail(avail), .i_queue_overflow(ev[3]),
      .i_queue_lost(ev[4]), .i_queue_empty_read(ev[5]), .i_meas_fault(ev[7]),
      .i_meas_end(ev[8]), .i_conv_done(ev[9]), .i_cmp_result(cmp),
      .i_cmp_valid(ev[10]), .o_queue_clear(qclr), .o_discard_msg(disc), .o_srq(srq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n = 1);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic cmd(input esr_pkg::esr_cmd_t c, input logic [7:0] d);
      esr_host_model_i.send(c, d);
   endtask

   task automatic query(input esr_pkg::esr_cmd_t c, input logic [7:0] exp);
      expq.push_back(exp);
      cmd(c, 8'h00);
   endtask

   // Waits until every queued command has been answered
   task automatic drain();
      while (esr_host_model_i.pend.size() != 0) begin
         tick();
      end
      tick(3);
   endtask

   task automatic pulse(input int i);
      ev[i] = 1'b1;
      tick();
      ev = '0;
      seen_qc = qclr;
      seen_dm = disc;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Response watcher pairs each answer with the oldest note
   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (expq.size() == 0) begin
            check("spare response", 8'h01, 8'h00);
         end else begin
            check("response", rsp_data, expq.pop_front());
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(99102));
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      tick();
      query(esr_pkg::CMD_STD_RD, 8'h80);
      query(esr_pkg::CMD_STD_RD, 8'h00);
      query(esr_pkg::CMD_MEAS_RD, 8'h00);
      query(esr_pkg::CMD_CMP_RD, 8'h00);
      for (int k = 0; k < 4; k++) begin
         query(rd_c[k], 8'h00);
         r = 8'($urandom());
         cmd(wr_c[k], r);
         query(rd_c[k], r);
         cmd(wr_c[k], 8'h00);
      end
      drain();
      // Every standard event source except operation complete, with its side effect
      for (int k = 0; k < 7; k++) begin
         pulse(k);
         check("queue_clear", 8'(seen_qc), 8'(k >= 3 && k <= 5));
         check("discard", 8'(seen_dm), 8'(k == 0));
         query(esr_pkg::CMD_STD_RD, 8'h01 << ev_bit[k]);
         drain();
      end
      gpib = 1'b0;
      pulse(5);
      query(esr_pkg::CMD_STD_RD, 8'h00);
      drain();
      gpib = 1'b1;
      cmd(esr_pkg::CMD_OPC, 8'h00);
      drain();
      query(esr_pkg::CMD_STD_RD, 8'h00);
      drain();
      idle = 1'b1;
      tick(3);
      idle = 1'b0;
      query(esr_pkg::CMD_STD_RD, 8'h01);
      drain();
      gpib = 1'b0;
      cmd(esr_pkg::CMD_OPC, 8'h00);
      drain();
      idle = 1'b1;
      tick(3);
      idle = 1'b0;
      gpib = 1'b1;
      query(esr_pkg::CMD_STD_RD, 8'h00);
      drain();
      // Device event flags
      pulse(7);
      pulse(8);
      pulse(9);
      r = 8'($urandom());
      cmp = r[5:0];
      pulse(10);
      query(esr_pkg::CMD_MEAS_RD, 8'h23);
      query(esr_pkg::CMD_CMP_RD, {2'b00, r[5:0]});
      query(esr_pkg::CMD_MEAS_RD, 8'h00);
      query(esr_pkg::CMD_CMP_RD, 8'h00);
      cmd(esr_pkg::CMD_MEASM_WR, 8'h02);
      cmd(esr_pkg::CMD_SRE_WR, 8'h01);
      drain();
      // Request raised two cycles after the event
      pulse(8);
      check("srq early", 8'(srq), 8'h00);
      tick();
      check("srq", 8'(srq), 8'h01);
      query(esr_pkg::CMD_STB_RD, 8'h41);
      query(esr_pkg::CMD_STB_RD, 8'h41);
      drain();
      check("srq after query", 8'(srq), 8'h01);
      query(esr_pkg::CMD_POLL, 8'h41);
      drain();
      check("srq after poll", 8'(srq), 8'h00);
      query(esr_pkg::CMD_STB_RD, 8'h41);
      cmd(esr_pkg::CMD_CLS, 8'h00);
      query(esr_pkg::CMD_STB_RD, 8'h00);
      query(esr_pkg::CMD_MEAS_RD, 8'h00);
      cmd(esr_pkg::CMD_SRE_WR, 8'h00);
      drain();
      pulse(8);
      tick(2);
      check("srq masked", 8'(srq), 8'h00);
      query(esr_pkg::CMD_STB_RD, 8'h01);
      cmd(esr_pkg::CMD_CLS, 8'h00);
      cmd(esr_pkg::CMD_STDM_WR, 8'h10);
      cmd(esr_pkg::CMD_SRE_WR, 8'h20);
      drain();
      avail = 1'b1;
      pulse(2);
      query(esr_pkg::CMD_STB_RD, 8'h10);
      drain();
      pulse(1);
      tick();
      query(esr_pkg::CMD_STB_RD, 8'h70);
      drain();
      check("srq std", 8'(srq), 8'h01);
      query(esr_pkg::CMD_STD_RD, 8'h18);
      query(esr_pkg::CMD_STB_RD, 8'h10);
      cmd(esr_pkg::CMD_CLS, 8'h00);
      // Measure and comparator masks open only the unused positions, so no summary may appear
      cmd(esr_pkg::CMD_MEASM_WR, 8'hDC);
      cmd(esr_pkg::CMD_CMPM_WR, 8'hC0);
      cmd(esr_pkg::CMD_SRE_WR, 8'h03);
      drain();
      avail = 1'b0;
      cmp = 6'h3F;
      for (int k = 7; k < 11; k++) begin
         pulse(k);
      end
      tick(2);
      check("srq unused", 8'(srq), 8'h00);
      query(esr_pkg::CMD_STB_RD, 8'h00);
      query(esr_pkg::CMD_CMP_RD, 8'h3F);
      drain();
      check("pending", 8'(expq.size()), 8'h00);
      give_verdict();
   end
endmodule // test_esr_top
